//--- src/chdm_monitor.sv
// Current harmonic distortion monitor: ratios, three pick-up elements, timers, APB settings
//
// Contract
// [RQ1] Each channel uses a full 32-component spectrum for its distortion calculation; the engine reads components 0..30 only, 31 is ignored.
// [RQ2] Five spectral inputs, three phases and two residuals, refreshed every 5 ms.
// [RQ3] Power ratio: sum of squared harmonics 2..31 over squared fundamental.
// [RQ4] Amplitude ratio: square root of the power ratio.
// [RQ5] One shared method setting picks amplitude or power; default amplitude.
// [RQ6] Mode on, blocked, test, test-and-blocked, off; default on; static setting. Here a CTRL write changes the mode at once.
// [RQ7] Three thresholds up to 100.00 % in 0.01 % steps, default 10.00 %.
// [RQ8] Phase element picks up when any phase exceeds the common phase threshold.
// [RQ9] Each residual element picks up on its own channel against its own threshold.
// [RQ10] Drop-out only below fixed 97 % of the threshold.
// [RQ11] Per-element enable, default enabled; disabled element never alarms.
// [RQ12] Thresholds, enables and delays change while running without restart.
// [RQ13] Blocking input sampled at start of each program cycle before pick-up.
// [RQ14] Pick-up without blocking asserts start and starts the operating delay.
// [RQ15] Pick-up with blocking asserts blocked; no start or alarm processing.
// [RQ16] Blocking after start clears start and releases as on pick-up reset.
// [RQ17] Blocking source asserts blocking at least 5 ms before delay expiry.
// [RQ18] Readable condition status: normal, start, alarm, blocked.
// [RQ19] Definite alarm delay 0..1800 s in 5 ms steps, default 10 s.
// [RQ20] Resettable cumulative counters for start, alarm and blocked.
// [RQ21] Thresholds and ratios are unsigned hundredths of a percent.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module chdm_monitor
  import chdm_pkg::*;
#(
  parameter int TICK_CYCLES = CHDM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Spectral inputs, one magnitude per component, component 0 is the fundamental
  input wire logic [CHDM_NUM_CH*CHDM_NUM_COMP*CHDM_MAG_W-1:0] spectrum_i,
  // Blocking matrix input
  input wire logic block_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Element outputs: phase, residual one, residual two
  output logic [2:0] start_o,
  output logic [2:0] alarm_o,
  output logic blocked_o,
  output chdm_pkg::chdm_cond_t monitor_condition_o
);
  import chdm_pkg::*;

  localparam int SPW = CHDM_NUM_COMP * CHDM_MAG_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Settings
  chdm_mode_t distortion_node_mode_r;
  logic amp_method_r;
  logic [2:0] enable_r;
  logic [CHDM_PCT_W-1:0] thr_r [3];
  logic [CHDM_TIME_W-1:0] dly_r [3];
  logic [CHDM_CNT_W-1:0] cnt_start_r;
  logic [CHDM_CNT_W-1:0] cnt_alarm_r;
  logic [CHDM_CNT_W-1:0] cnt_block_r;
  logic [CHDM_PCT_W-1:0] ratio_r [CHDM_NUM_CH];
  logic apb_wr;
  logic apb_rd;
  logic cnt_clr;
  logic [31:0] rdata_nxt;
  logic err_nxt;

  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign apb_rd = psel_i & penable_i & ~pwrite_i;
  assign cnt_clr = apb_wr && paddr_i == CHDM_A_CNT_CLR;

  // Writes take effect at once; timers keep running, so new values apply mid-flight
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      distortion_node_mode_r <= CHDM_MODE_ON; // [RQ6]
      amp_method_r <= 1'b1; // [RQ5]
      enable_r <= 3'h7; // [RQ11]
      for (int i = 0; i < 3; i++) begin
        thr_r[i] <= CHDM_THR_RST; // [RQ7]
        dly_r[i] <= CHDM_DLY_RST; // [RQ19]
      end
    end else if (apb_wr) begin
      if (paddr_i == CHDM_A_CTRL) begin
        if (pwdata_i[CHDM_CTRL_MODE_LSB +: 3] <= 3'(CHDM_MODE_OFF)) begin
          distortion_node_mode_r <= chdm_mode_t'(pwdata_i[CHDM_CTRL_MODE_LSB +: 3]);
        end
        amp_method_r <= pwdata_i[CHDM_CTRL_METHOD_BIT];
        enable_r <= pwdata_i[CHDM_CTRL_EN_LSB +: 3]; // [RQ12]
      end
      for (int i = 0; i < 3; i++) begin
        if (paddr_i == CHDM_A_THR_PH + 8'(4 * i) && pwdata_i[CHDM_PCT_W-1:0] <= CHDM_PCT_FULL) begin
          thr_r[i] <= pwdata_i[CHDM_PCT_W-1:0]; // [RQ12]
        end
        if (paddr_i == CHDM_A_DLY_PH + 8'(4 * i) && pwdata_i[CHDM_TIME_W-1:0] <= CHDM_DLY_MAX) begin
          dly_r[i] <= pwdata_i[CHDM_TIME_W-1:0]; // [RQ12]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program cycle tick and input sampling
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
  logic tick;
  logic block_s1_r;
  logic block_s2_r;
  logic block_r;
  logic [CHDM_NUM_CH*SPW-1:0] spec_r;

  assign tick = tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1; // [RQ2]
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      block_s1_r <= 1'b0;
      block_s2_r <= 1'b0;
    end else begin
      block_s1_r <= block_i;
      block_s2_r <= block_s1_r;
    end
  end

  // Spectra are assumed steady over a program cycle; they are latched on the tick
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      spec_r <= '0;
      block_r <= 1'b0;
    end else if (tick) begin
      spec_r <= spectrum_i; // [RQ2]
      block_r <= block_s2_r; // [RQ13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel sequencer through the shared ratio engine
  typedef enum logic [2:0] {SQ_IDLE = 3'h1, SQ_RUN = 3'h2, SQ_EVAL = 3'h4} chdm_seq_t;
  chdm_seq_t seq_r;
  logic [2:0] ch_r;
  logic eng_start_r;
  logic eval;

  chdm_ratio_if rif ();

  assign rif.start = eng_start_r;
  assign rif.amp_mode = amp_method_r; // [RQ5]
  assign rif.spectrum = spec_r[ch_r*SPW +: SPW]; // [RQ1]
  assign eval = seq_r == SQ_EVAL;

  chdm_ratio_engine u_eng (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .rq(rif.eng)
  );

  // Timer work runs once per program cycle after all five ratios are ready
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_r <= SQ_IDLE;
      ch_r <= 3'h0;
      eng_start_r <= 1'b0;
      for (int i = 0; i < CHDM_NUM_CH; i++) begin
        ratio_r[i] <= '0;
      end
    end else begin
      eng_start_r <= 1'b0;
      case (seq_r)
        SQ_IDLE: begin
          if (tick) begin
            ch_r <= 3'h0;
            eng_start_r <= 1'b1;
            seq_r <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          if (rif.done) begin
            ratio_r[ch_r] <= rif.result; // [RQ21]
            if (ch_r == 3'(CHDM_NUM_CH - 1)) begin
              seq_r <= SQ_EVAL;
            end else begin
              ch_r <= ch_r + 3'h1;
              eng_start_r <= 1'b1;
            end
          end
        end
        default: begin
          seq_r <= SQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pick-up elements with 97 % drop-out, timers and blocking
  logic [2:0] pickup_r;
  logic [2:0] start_r;
  logic [2:0] alarm_r;
  logic [2:0] blk_r;
  logic [CHDM_TIME_W-1:0] tmr_r [3];
  logic [2:0] over;
  logic [2:0] under;
  logic blocking;
  logic active;

  // Test mode is treated as on and test-and-blocked as blocked; the outputs are not suppressed here
  assign active = distortion_node_mode_r != CHDM_MODE_OFF;
  assign blocking = block_r || distortion_node_mode_r == CHDM_MODE_BLOCKED ||
    distortion_node_mode_r == CHDM_MODE_TEST_BLOCKED;

  generate
    for (genvar e = 0; e < 3; e++) begin : g_elem
      logic [CHDM_PCT_W+6:0] lo_lim;
      logic [CHDM_PCT_W+6:0] lo_meas [3];
      assign lo_lim = (CHDM_PCT_W+7)'(thr_r[e]) * (CHDM_PCT_W+7)'(CHDM_RESET_RATIO_PCT);
      for (genvar k = 0; k < 3; k++) begin : g_m
        assign lo_meas[k] = (CHDM_PCT_W+7)'(ratio_r[e == 0 ? k : e + 2]) * (CHDM_PCT_W+7)'(CHDM_RATIO_DEN);
      end
      if (e == 0) begin : g_ph
        assign over[e] = ratio_r[0] > thr_r[0] || ratio_r[1] > thr_r[0] || ratio_r[2] > thr_r[0]; // [RQ8]
        assign under[e] = lo_meas[0] < lo_lim && lo_meas[1] < lo_lim && lo_meas[2] < lo_lim; // [RQ10]
      end else begin : g_res
        assign over[e] = ratio_r[e+2] > thr_r[e]; // [RQ9]
        assign under[e] = lo_meas[0] < lo_lim; // [RQ10]
      end

      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          pickup_r[e] <= 1'b0;
          start_r[e] <= 1'b0;
          alarm_r[e] <= 1'b0;
          blk_r[e] <= 1'b0;
          tmr_r[e] <= '0;
        end else if (eval) begin
          if (!active || !enable_r[e]) begin
            pickup_r[e] <= 1'b0; // [RQ11]
            start_r[e] <= 1'b0;
            alarm_r[e] <= 1'b0;
            blk_r[e] <= 1'b0;
            tmr_r[e] <= '0;
          end else begin
            if (over[e]) begin
              pickup_r[e] <= 1'b1;
            end else if (under[e]) begin
              pickup_r[e] <= 1'b0; // [RQ10]
            end
            if ((over[e] || (pickup_r[e] && !under[e])) && blocking) begin
              blk_r[e] <= 1'b1; // [RQ15]
              start_r[e] <= 1'b0; // [RQ16]
              alarm_r[e] <= 1'b0;
              tmr_r[e] <= '0;
            end else if (over[e] || (pickup_r[e] && !under[e])) begin
              blk_r[e] <= 1'b0;
              start_r[e] <= 1'b1; // [RQ14]
              // One timer step per 5 ms program cycle
              if (tmr_r[e] + 1'b1 >= dly_r[e] || dly_r[e] == '0) begin
                alarm_r[e] <= 1'b1; // [RQ19]
              end else begin
                tmr_r[e] <= tmr_r[e] + 1'b1;
              end
            end else begin
              blk_r[e] <= 1'b0;
              start_r[e] <= 1'b0;
              alarm_r[e] <= 1'b0;
              tmr_r[e] <= '0;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, condition and event counters
  logic [2:0] start_q_r;
  logic [2:0] alarm_q_r;
  logic blk_q_r;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      start_o <= 3'h0;
      alarm_o <= 3'h0;
      blocked_o <= 1'b0;
      monitor_condition_o <= CHDM_COND_NORMAL;
    end else begin
      start_o <= start_r;
      alarm_o <= alarm_r;
      blocked_o <= |blk_r;
      if (|alarm_r) begin
        monitor_condition_o <= CHDM_COND_ALARM; // [RQ18]
      end else if (|start_r) begin
        monitor_condition_o <= CHDM_COND_START;
      end else if (|blk_r) begin
        monitor_condition_o <= CHDM_COND_BLOCKED;
      end else begin
        monitor_condition_o <= CHDM_COND_NORMAL;
      end
    end
  end

  // Counts rising edges; a clear in the same cycle as an event keeps the event
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      start_q_r <= 3'h0;
      alarm_q_r <= 3'h0;
      blk_q_r <= 1'b0;
      cnt_start_r <= '0;
      cnt_alarm_r <= '0;
      cnt_block_r <= '0;
    end else begin
      start_q_r <= start_r;
      alarm_q_r <= alarm_r;
      blk_q_r <= |blk_r;
      cnt_start_r <= (cnt_clr ? '0 : cnt_start_r) + CHDM_CNT_W'(|(start_r & ~start_q_r)); // [RQ20]
      cnt_alarm_r <= (cnt_clr ? '0 : cnt_alarm_r) + CHDM_CNT_W'(|(alarm_r & ~alarm_q_r)); // [RQ20]
      cnt_block_r <= (cnt_clr ? '0 : cnt_block_r) + CHDM_CNT_W'((|blk_r) & ~blk_q_r); // [RQ20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB read path, zero wait states
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr_i == CHDM_A_CTRL) begin
      rdata_nxt[CHDM_CTRL_MODE_LSB +: 3] = distortion_node_mode_r;
      rdata_nxt[CHDM_CTRL_METHOD_BIT] = amp_method_r;
      rdata_nxt[CHDM_CTRL_EN_LSB +: 3] = enable_r;
    end else if (paddr_i == CHDM_A_THR_PH) begin
      rdata_nxt[CHDM_PCT_W-1:0] = thr_r[0];
    end else if (paddr_i == CHDM_A_THR_R1) begin
      rdata_nxt[CHDM_PCT_W-1:0] = thr_r[1];
    end else if (paddr_i == CHDM_A_THR_R2) begin
      rdata_nxt[CHDM_PCT_W-1:0] = thr_r[2];
    end else if (paddr_i == CHDM_A_DLY_PH) begin
      rdata_nxt[CHDM_TIME_W-1:0] = dly_r[0];
    end else if (paddr_i == CHDM_A_DLY_R1) begin
      rdata_nxt[CHDM_TIME_W-1:0] = dly_r[1];
    end else if (paddr_i == CHDM_A_DLY_R2) begin
      rdata_nxt[CHDM_TIME_W-1:0] = dly_r[2];
    end else if (paddr_i == CHDM_A_STATUS) begin
      rdata_nxt[3:0] = monitor_condition_o; // [RQ18]
      rdata_nxt[6:4] = start_r;
      rdata_nxt[10:8] = alarm_r;
      rdata_nxt[14:12] = blk_r;
      rdata_nxt[16] = block_r;
    end else if (paddr_i == CHDM_A_CNT_START) begin
      rdata_nxt[CHDM_CNT_W-1:0] = cnt_start_r;
    end else if (paddr_i == CHDM_A_CNT_ALARM) begin
      rdata_nxt[CHDM_CNT_W-1:0] = cnt_alarm_r;
    end else if (paddr_i == CHDM_A_CNT_BLOCK) begin
      rdata_nxt[CHDM_CNT_W-1:0] = cnt_block_r;
    end else if (paddr_i == CHDM_A_CNT_CLR) begin
      rdata_nxt = 32'h0000_0000;
    end else if (paddr_i >= CHDM_A_RES_BASE && paddr_i < CHDM_A_RES_BASE + 8'h14 && paddr_i[1:0] == 2'h0) begin
      rdata_nxt[CHDM_PCT_W-1:0] = ratio_r[3'((paddr_i - CHDM_A_RES_BASE) >> 2)]; // [RQ21]
    end else begin
      err_nxt = 1'b1;
    end
  end

  // pready rises in the first access cycle and is registered as required of outputs
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & err_nxt;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_o <= rdata_nxt;
      end
    end
  end
endmodule

//--- src/chdm_pkg.sv
// Shared constants and types for the current harmonic distortion monitor
package chdm_pkg;
  localparam int CHDM_NUM_CH = 5;
  localparam int CHDM_NUM_COMP = 32;
  localparam int CHDM_MAG_W = 16;
  localparam int CHDM_PCT_W = 14;
  localparam int CHDM_CNT_W = 16;
  localparam int CHDM_TIME_W = 19;
  localparam int CHDM_CLK_HZ = 20000000;
  localparam int CHDM_TICK_US = 5000;
  localparam int CHDM_TICK_CYCLES = CHDM_CLK_HZ / 1000000 * CHDM_TICK_US;
  localparam int CHDM_DELAY_STEP_MS = 5;
  localparam logic [CHDM_PCT_W-1:0] CHDM_PCT_FULL = 14'h2710;
  localparam logic [CHDM_PCT_W-1:0] CHDM_THR_RST = 14'h03E8;
  localparam logic [CHDM_TIME_W-1:0] CHDM_DLY_RST = 19'h007D0;
  localparam logic [CHDM_TIME_W-1:0] CHDM_DLY_MAX = 19'h57E40;
  localparam logic [6:0] CHDM_RESET_RATIO_PCT = 7'h61;
  localparam logic [6:0] CHDM_RATIO_DEN = 7'h64;
  // APB map
  localparam logic [7:0] CHDM_A_CTRL = 8'h00;
  localparam logic [7:0] CHDM_A_THR_PH = 8'h04;
  localparam logic [7:0] CHDM_A_THR_R1 = 8'h08;
  localparam logic [7:0] CHDM_A_THR_R2 = 8'h0C;
  localparam logic [7:0] CHDM_A_DLY_PH = 8'h10;
  localparam logic [7:0] CHDM_A_DLY_R1 = 8'h14;
  localparam logic [7:0] CHDM_A_DLY_R2 = 8'h18;
  localparam logic [7:0] CHDM_A_STATUS = 8'h1C;
  localparam logic [7:0] CHDM_A_CNT_START = 8'h20;
  localparam logic [7:0] CHDM_A_CNT_ALARM = 8'h24;
  localparam logic [7:0] CHDM_A_CNT_BLOCK = 8'h28;
  localparam logic [7:0] CHDM_A_CNT_CLR = 8'h2C;
  localparam logic [7:0] CHDM_A_RES_BASE = 8'h30;
  // CTRL fields
  localparam int CHDM_CTRL_MODE_LSB = 0;
  localparam int CHDM_CTRL_METHOD_BIT = 4;
  localparam int CHDM_CTRL_EN_LSB = 8;
  typedef enum logic [2:0] {
    CHDM_MODE_ON = 3'h0,
    CHDM_MODE_BLOCKED = 3'h1,
    CHDM_MODE_TEST = 3'h2,
    CHDM_MODE_TEST_BLOCKED = 3'h3,
    CHDM_MODE_OFF = 3'h4
  } chdm_mode_t;
  typedef enum logic [3:0] {
    CHDM_COND_NORMAL = 4'h1,
    CHDM_COND_START = 4'h2,
    CHDM_COND_ALARM = 4'h4,
    CHDM_COND_BLOCKED = 4'h8
  } chdm_cond_t;
endpackage

//--- src/chdm_ratio_engine.sv
// Sequential distortion ratio engine: one spectrum in, ratio in 0.01 % out
`timescale 1ns/100ps
module chdm_ratio_engine
  import chdm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Request and result
  chdm_ratio_if.eng rq
);
  import chdm_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_SUM = 5'h02, ST_DIV = 5'h04, ST_SQRT = 5'h08, ST_DONE = 5'h10
  } chdm_eng_st_t;

  localparam int ACC_W = 2 * CHDM_MAG_W + 5;
  localparam int QW = 28;
  // Compare window wide enough for twice the largest fundamental power
  localparam int RW = 2 * CHDM_MAG_W + 1;

  chdm_eng_st_t st_r;
  logic [4:0] idx_r;
  logic [ACC_W-1:0] acc_r;
  logic [2*CHDM_MAG_W-1:0] fund_r;
  logic [QW-1:0] quot_r;
  logic [ACC_W+QW-1:0] rem_r;
  logic [5:0] bit_r;
  logic [CHDM_PCT_W-1:0] root_r;
  logic [CHDM_PCT_W-1:0] result_r;
  logic done_r;
  logic [CHDM_MAG_W-1:0] mag;
  logic [ACC_W+QW-1:0] rem_sh;
  logic [CHDM_PCT_W-1:0] trial;
  logic [2*CHDM_PCT_W-1:0] trial_sq;
  logic [RW-1:0] part;
  logic geq;

  assign mag = rq.spectrum[idx_r*CHDM_MAG_W +: CHDM_MAG_W];
  assign rem_sh = {rem_r[ACC_W+QW-2:0], 1'b0};
  assign trial = root_r | CHDM_PCT_W'(1 << bit_r[3:0]);
  assign trial_sq = trial * trial;
  assign part = rem_r[ACC_W+QW-1 -: RW];
  assign geq = part >= RW'(fund_r);
  assign rq.done = done_r;
  assign rq.result = result_r;

  // Harmonic sum, division by fundamental and optional square root
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      idx_r <= 5'h00;
      acc_r <= '0;
      fund_r <= '0;
      quot_r <= '0;
      rem_r <= '0;
      bit_r <= 6'h00;
      root_r <= '0;
      result_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (rq.start) begin
            idx_r <= 5'h00;
            acc_r <= '0;
            st_r <= ST_SUM;
          end
        end
        ST_SUM: begin
          // Component 0 is the fundamental, 1..31 are harmonics 2..32 of the spectrum index
          if (idx_r == 5'h00) begin
            fund_r <= mag * mag; // [RQ1]
          end else if (idx_r <= 5'h1E) begin
            acc_r <= acc_r + ACC_W'(mag) * ACC_W'(mag); // [RQ3]
          end
          if (idx_r == 5'h1F) begin
            // Power ratio scaled to 0.01 %: acc * 10000 / fund, aligned for quotient bits 27..0
            rem_r <= ((ACC_W+QW)'(acc_r) * (ACC_W+QW)'(CHDM_PCT_FULL)) << (ACC_W - RW + 1);
            quot_r <= '0;
            bit_r <= 6'(QW);
            st_r <= ST_DIV;
          end
          idx_r <= idx_r + 5'h01;
        end
        ST_DIV: begin
          // Restoring division, one quotient bit per cycle
          // No fundamental or a quotient past 27 bits saturates
          if (fund_r == '0 || (bit_r == 6'(QW) && geq)) begin
            quot_r <= {QW{1'b1}};
            bit_r <= 6'(CHDM_PCT_W - 1);
            root_r <= '0;
            st_r <= rq.amp_mode ? ST_SQRT : ST_DONE;
          end else if (bit_r == 6'h00) begin
            bit_r <= 6'(CHDM_PCT_W - 1);
            root_r <= '0;
            st_r <= rq.amp_mode ? ST_SQRT : ST_DONE;
          end else begin
            quot_r <= {quot_r[QW-2:0], geq};
            rem_r <= geq ? {part - RW'(fund_r), rem_r[ACC_W+QW-RW-1:0]} << 1 : rem_sh;
            bit_r <= bit_r - 6'h01;
          end
        end
        ST_SQRT: begin
          // Amplitude ratio: sqrt(q/10000)*10000 = sqrt(q*10000), bitwise root
          if ((QW+CHDM_PCT_W+1)'(trial_sq) <= (QW+CHDM_PCT_W+1)'(quot_r) * (QW+CHDM_PCT_W+1)'(CHDM_PCT_FULL)) begin
            root_r <= trial; // [RQ4]
          end
          if (bit_r == 6'h00) begin
            st_r <= ST_DONE;
          end else begin
            bit_r <= bit_r - 6'h01;
          end
        end
        default: begin
          if (rq.amp_mode) begin
            result_r <= (root_r > CHDM_PCT_FULL) ? CHDM_PCT_FULL : root_r;
          end else begin
            result_r <= (quot_r > QW'(CHDM_PCT_FULL)) ? CHDM_PCT_FULL : quot_r[CHDM_PCT_W-1:0];
          end
          done_r <= 1'b1;
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

//--- src/chdm_ratio_if.sv
// Handshake between the sequencer and the distortion ratio engine
`timescale 1ns/100ps
interface chdm_ratio_if;
  import chdm_pkg::*;
  logic start;
  logic amp_mode;
  logic [CHDM_NUM_COMP*CHDM_MAG_W-1:0] spectrum;
  logic done;
  logic [CHDM_PCT_W-1:0] result;
  modport ctrl (output start, output amp_mode, output spectrum, input done, input result);
  modport eng (input start, input amp_mode, input spectrum, output done, output result);
endinterface

//--- tb/chdm_monitor_asserts.sv
// Port checker for the harmonic distortion monitor
`timescale 1ns/100ps
module chdm_monitor_asserts
  import chdm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Elements
  input wire logic [2:0] start_o,
  input wire logic [2:0] alarm_o,
  input wire logic blocked_o,
  input wire chdm_pkg::chdm_cond_t monitor_condition_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  property p_setup; psel_i && !penable_i |=> pready_o; endproperty
  a_setup: assert property (p_setup) else $error("no ready after setup");
  property p_once; pready_o |=> !pready_o; endproperty
  a_once: assert property (p_once) else $error("ready held too long");
  property p_idle; !psel_i |=> !pready_o; endproperty
  a_idle: assert property (p_idle) else $error("ready while idle");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd0; pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("refused read not zero");
  property p_blk; blocked_o |-> start_o == 3'h0 && alarm_o == 3'h0; endproperty
  a_blk: assert property (p_blk) else $error("start or alarm while blocked");
  property p_cblk; blocked_o |-> monitor_condition_o == CHDM_COND_BLOCKED; endproperty
  a_cblk: assert property (p_cblk) else $error("condition not blocked");
  property p_norm; !blocked_o && !(|start_o) && !(|alarm_o) |-> monitor_condition_o == CHDM_COND_NORMAL; endproperty
  a_norm: assert property (p_norm) else $error("condition not normal");
  c_blk: cover property (blocked_o);
  c_alm: cover property (alarm_o == 3'h7);
  c_err: cover property (pslverr_o);
endmodule
bind chdm_monitor chdm_monitor_asserts chk_u (.*);

//--- tb/chdm_spec_model.sv
// Behavioural spectral front end and blocking matrix
`timescale 1ns/100ps
module chdm_spec_model
  import chdm_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Levels set by the bench
  input wire logic [CHDM_MAG_W-1:0] fund_i,
  input wire logic [CHDM_NUM_CH*CHDM_MAG_W-1:0] harm_i,
  input wire logic blk_i,
  // Towards the monitor
  output logic [CHDM_NUM_CH*CHDM_NUM_COMP*CHDM_MAG_W-1:0] spectrum_o = '0,
  output logic block_o = 1'b0
);
  logic [CHDM_MAG_W-1:0] junk = 16'h5A5A;
  // Unused top slot churns every cycle, so a wrong index cannot hide
  always @(posedge mclk_i) begin
    junk <= ~junk;
    block_o <= blk_i;
    for (int c = 0; c < CHDM_NUM_CH; c++) begin
      spectrum_o[c*512 +: 512] <= {junk, 464'h0, harm_i[c*16 +: 16], fund_i};
    end
  end
endmodule

//--- tb/tb_current_harmonic_distortion_monitor.sv
// Directed testbench for the harmonic distortion monitor
`timescale 1ns/100ps
module tb_current_harmonic_distortion_monitor;
  import chdm_pkg::*;
  logic mclk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, blk = 0, err;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, q, prdata_o;
  logic [15:0] fund = 16'h03E8;
  logic [79:0] harm = 80'h0;
  logic [2559:0] spectrum_i;
  logic block_i, pready_o, pslverr_o, blocked_o;
  logic [2:0] start_o, alarm_o;
  logic [6:0] el;
  chdm_cond_t monitor_condition_o;
  int fail_count = 0, tests_run = 0;
  assign el = {blocked_o, start_o, alarm_o};
  // Short tick keeps the run small; each tick stands for 5 ms
  chdm_monitor #(.TICK_CYCLES(1000)) dut_u (.*);
  chdm_spec_model mdl_u (.mclk_i(mclk_i), .fund_i(fund), .harm_i(harm), .blk_i(blk),
    .spectrum_o(spectrum_i), .block_o(block_i));
  initial forever #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(8);
    reset_i <= 0;
    rd(CHDM_A_CTRL, 32'h710);
    for (int i = 0; i < 3; i++) begin
      rd(CHDM_A_THR_PH + 8'(4*i), 32'h3E8);
      rd(CHDM_A_DLY_PH + 8'(4*i), 32'h7D0);
      apb(1, CHDM_A_DLY_PH + 8'(4*i), 32'h4);
    end
    rd(CHDM_A_STATUS, 32'h1);
    rd(8'hFC, 32'h0);
    chk(32'(err), 32'h1);
    $display("test 1 done");
    harm <= {5{16'h00C8}};
    cyc(1500);
    chk(32'(el), 32'h38);
    cyc(5000);
    chk(32'(alarm_o), 32'h7);
    chk(32'(monitor_condition_o), 32'(CHDM_COND_ALARM));
    for (int i = 0; i < 5; i++) rd(CHDM_A_RES_BASE + 8'(4*i), 32'h7D0);
    rd(CHDM_A_CNT_START, 32'h1);
    rd(CHDM_A_CNT_ALARM, 32'h1);
    $display("test 2 done");
    apb(1, CHDM_A_THR_PH, 32'h80D);
    cyc(2500);
    chk(32'(alarm_o), 32'h7);
    apb(1, CHDM_A_THR_PH, 32'h80F);
    cyc(2500);
    chk(32'(alarm_o), 32'h6);
    apb(1, CHDM_A_THR_R1, 32'h2711);
    rd(CHDM_A_THR_R1, 32'h3E8);
    $display("test 3 done");
    blk <= 1;
    cyc(2500);
    chk(32'(el), 32'h40);
    rd(CHDM_A_CNT_BLOCK, 32'h1);
    apb(1, CHDM_A_CNT_CLR, 32'h0);
    rd(CHDM_A_CNT_BLOCK, 32'h0);
    blk <= 0;
    $display("test 4 done");
    apb(1, CHDM_A_CTRL, 32'h700);
    cyc(2500);
    rd(CHDM_A_RES_BASE, 32'h190);
    chk(32'(el), 32'h0);
    $display("test 5 done");
    harm <= {16'h0, 16'h00C8, 16'h0, 16'h00C8, 16'h0};
    apb(1, CHDM_A_THR_PH, 32'h3E8);
    apb(1, CHDM_A_CTRL, 32'h510);
    cyc(2500);
    chk(32'(start_o | alarm_o), 32'h1);
    $display("test 6 done");
    apb(1, CHDM_A_CTRL, 32'h515);
    rd(CHDM_A_CTRL, 32'h510);
    apb(1, CHDM_A_CTRL, 32'h511);
    cyc(2500);
    chk(32'(el), 32'h40);
    apb(1, CHDM_A_CTRL, 32'h514);
    cyc(2500);
    chk(32'(el), 32'h0);
    $display("test 7 done");
    end_of_test();
  end
  initial begin
    #2000000;
    fail_count++;
    end_of_test();
  end
endmodule
